//--- pkg/sfph_params.svh
// constants of the serial flash guard and pause block
// assumes inclusion by bare name from pkg/ on the search path
`ifndef SFPH_PARAMS_SVH
`define SFPH_PARAMS_SVH

// ==================================================
// opcodes
`define SFPH_OPC_STATUS_WR 8'h01
`define SFPH_OPC_BYTE_PROG 8'h02
`define SFPH_OPC_STATUS_RD 8'h05
`define SFPH_OPC_SECT_ERASE 8'h20
`define SFPH_OPC_CHIP_ERASE 8'h60
`define SFPH_OPC_AAI_PROG 8'hAF

// ==================================================
// bit counts at which a sequence is complete, and the count at which the counter stops
`define SFPH_CNT_OPC 6'h08
`define SFPH_CNT_STATUS 6'h10
`define SFPH_CNT_ADDR 6'h20
`define SFPH_CNT_PROG 6'h28
`define SFPH_CNT_MAX 6'h3F

// ==================================================
// status register fields and power-up values
`define SFPH_SR_LEVEL_LO 2
`define SFPH_SR_LEVEL_HI 3
`define SFPH_SR_LOCKDOWN 7
`define SFPH_LEVEL_RST 2'h3
`define SFPH_LOCK_RST 1'h0

// ==================================================
// sector numbers where guard levels 1 and 2 begin
`define SFPH_SECT_LEVEL1 4'h7
`define SFPH_SECT_LEVEL2 4'h6

`endif

//--- pkg/sfph_pkg.sv
// types of the serial flash guard and pause block
// assumes nothing beyond a SystemVerilog compiler
package sfph_pkg;

   typedef enum logic [1:0] {
      SFPH_ARR_PROG  = 2'h0,
      SFPH_ARR_SECT  = 2'h1,
      SFPH_ARR_CHIP  = 2'h2,
      SFPH_ARR_NONE  = 2'h3
   } sfph_arr_op_t;

   typedef enum logic {
      SFPH_RUN   = 1'b0,
      SFPH_PAUSE = 1'b1
   } sfph_pause_t;

endpackage

//--- pkg/sfph_guard_if.sv
// address to sector and guard check link between the top and the checker
// assumes sfph_pkg is compiled first
interface sfph_guard_if;
   logic [18:0] addr;
   logic [1:0] level;
   logic [3:0] sector;
   logic prot;

   modport chk (input addr, input level, output sector, output prot);
   modport use_side (output addr, output level, input sector, input prot);
endinterface

//--- verilog/sfph_guard.sv
// sector decode and guard-level range check, purely combinational
// assumes the caller holds the address and level steady for a cycle
`include "sfph_params.svh"

module sfph_guard
   import sfph_pkg::*;
(
   // check link
   sfph_guard_if.chk gi
);

   // ==================================================
   // sector decode
   function automatic logic [3:0] sect_of(input logic [18:0] a);
      logic [3:0] s;
      s = {1'b0, a[18:16]};
      if (a[18:16] == 3'h7) begin
         if (!a[15]) s = 4'h7;
         else if (!a[14]) s = 4'h8;
         else if (!a[13]) s = a[12] ? 4'hA : 4'h9;
         else s = 4'hB;
      end
      return s;
   endfunction

   always_comb begin
      gi.sector = sect_of(gi.addr);
      unique case (gi.level)
         2'h0: gi.prot = 1'b0;
         2'h1: gi.prot = gi.sector >= `SFPH_SECT_LEVEL1;
         2'h2: gi.prot = gi.sector >= `SFPH_SECT_LEVEL2;
         2'h3: gi.prot = 1'b1;
      endcase
   end

endmodule

//--- verilog/sfph_top.sv
// write guard, status guard bits and pause logic of a serial flash, memory side
// assumes pins arrive asynchronously to SYS_CLK and SCK is far slower than it
`include "sfph_params.svh"

// Operation
// - sample serial input on each rising serial clock edge while selected and not paused
// - change serial output on falling serial clock edges
// - respond only while select is low, stay idle while high
// - serial clock modes 0 and 3 only, sampling on rising edges
// - decode A18..A12 into twelve sectors of varying size
// - guard levels 00 none, 01 top 64K, 10 top 128K, 11 everything
// - refuse program or erase whose target lies in the guarded range
// - status write updates guard level only if guard pin high or lockdown clear
// - whole-array erase only when guard level is zero
// - power-up guard level is 11, whole array protected
// - power-up lockdown is zero
// - guard pin low with lockdown set rejects status write, bits unchanged
// - guard pin high makes lockdown a don't care
// - lockdown sits in status bit 7, qualified by the guard pin
// - pause pin falling enters pause once serial clock is low, while selected
// - pause pin rising leaves pause once serial clock is low
// - paused: output floats, serial input and clock ignored
// - select high while paused resets serial logic, sequence dropped
// - guard level low bit 2, high bit 3; only these and lockdown writable
module sfph_top
   import sfph_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   // serial pins
   input wire logic SCK,
   input wire logic SI,
   input wire logic CS_N,
   input wire logic WRITE_GUARD_N,
   input wire logic PAUSE_N,
   output logic SO,
   output logic SO_OE_N,
   // array command side
   output logic ARRAY_REQ,
   output sfph_arr_op_t ARRAY_OP,
   output logic [18:0] ARRAY_ADDR,
   output logic [7:0] ARRAY_DATA,
   output logic CMD_REFUSED,
   // status
   output logic [1:0] GUARD_LEVEL,
   output logic GUARD_LOCKDOWN,
   output logic PAUSED
);

   // ==================================================
   // pin synchronisers
   logic [1:0] sck_q, si_q, cs_q, wg_q, pn_q;
   logic sck_d, cs_d;

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sck_q <= 2'h0;
         si_q <= 2'h0;
         cs_q <= 2'h3;
         wg_q <= 2'h3;
         pn_q <= 2'h3;
         sck_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sck_q <= {sck_q[0], SCK};
         si_q <= {si_q[0], SI};
         cs_q <= {cs_q[0], CS_N};
         wg_q <= {wg_q[0], WRITE_GUARD_N};
         pn_q <= {pn_q[0], PAUSE_N};
         sck_d <= sck_q[1];
         cs_d <= cs_q[1];
      end
   end

   logic sck_s, si_s, cs_s, wg_s, pn_s;
   assign sck_s = sck_q[1];
   assign si_s = si_q[1];
   assign cs_s = cs_q[1];
   assign wg_s = wg_q[1];
   assign pn_s = pn_q[1];

   logic sck_rise, sck_fall, cs_rise;
   assign sck_rise = sck_s & ~sck_d;
   assign sck_fall = ~sck_s & sck_d;
   assign cs_rise = cs_s & ~cs_d;

   // ==================================================
   // pause state
   sfph_pause_t pause_r, pause_nxt;

   always_comb begin
      pause_nxt = pause_r;
      unique case (pause_r)
         SFPH_RUN: if (!pn_s && !sck_s && !cs_s) pause_nxt = SFPH_PAUSE;
         SFPH_PAUSE: if (pn_s && !sck_s) pause_nxt = SFPH_RUN;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) pause_r <= SFPH_RUN;
      else pause_r <= pause_nxt;
   end

   logic paused;
   assign paused = (pause_r == SFPH_PAUSE);

   // ==================================================
   // serial shifter
   logic [5:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, op_r, op_nxt, dat_r, dat_nxt, out_r, out_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic so_r, so_nxt, oe_n_r, oe_n_nxt;
   logic [7:0] status_byte;
   logic active, take, rd_stat;

   // paused: clock and data lines ignored
   assign active = ~cs_s & ~paused;
   assign take = active & sck_rise;
   assign rd_stat = (op_r == `SFPH_OPC_STATUS_RD) && (cnt_r >= `SFPH_CNT_OPC);

   always_comb begin
      status_byte = 8'h00;
      status_byte[`SFPH_SR_LEVEL_LO] = GUARD_LEVEL[0];
      status_byte[`SFPH_SR_LEVEL_HI] = GUARD_LEVEL[1];
      status_byte[`SFPH_SR_LOCKDOWN] = GUARD_LOCKDOWN;
   end

   always_comb begin
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      op_nxt = op_r;
      dat_nxt = dat_r;
      addr_nxt = addr_r;
      out_nxt = out_r;
      so_nxt = so_r;
      if (cs_s) begin
         // deselect ends every sequence, paused or not
         cnt_nxt = 6'h00;
         op_nxt = 8'h00;
      end else if (take) begin
         sh_nxt = {sh_r[6:0], si_s};
         if (cnt_r != `SFPH_CNT_MAX) cnt_nxt = cnt_r + 6'h01;
         if (cnt_r >= `SFPH_CNT_OPC && cnt_r < `SFPH_CNT_ADDR) addr_nxt = {addr_r[22:0], si_s};
         if (cnt_nxt == `SFPH_CNT_OPC) begin
            op_nxt = sh_nxt;
            out_nxt = status_byte;
         end
         if (cnt_nxt == `SFPH_CNT_STATUS || cnt_nxt == `SFPH_CNT_PROG) dat_nxt = sh_nxt;
      end else if (active && sck_fall && rd_stat) begin
         so_nxt = out_r[7];
         out_nxt = {out_r[6:0], out_r[7]};
      end
      oe_n_nxt = ~(active & rd_stat);
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_r <= 6'h00;
         sh_r <= 8'h00;
         op_r <= 8'h00;
         dat_r <= 8'h00;
         addr_r <= 24'h000000;
         out_r <= 8'h00;
         so_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         op_r <= op_nxt;
         dat_r <= dat_nxt;
         addr_r <= addr_nxt;
         out_r <= out_nxt;
         so_r <= so_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end

   assign SO = so_r;
   assign SO_OE_N = oe_n_r;
   assign PAUSED = paused;

   // ==================================================
   // guard check
   sfph_guard_if gi ();
   sfph_guard u_guard (.gi(gi.chk));
   assign gi.addr = addr_r[18:0];
   assign gi.level = GUARD_LEVEL;

   // ==================================================
   // command execution at deselect
   logic [1:0] level_r, level_nxt;
   logic lock_r, lock_nxt, req_r, req_nxt, ref_r, ref_nxt;
   sfph_arr_op_t aop_r, aop_nxt;
   logic exec, is_wr, is_prog, is_sect, is_chip, wr_ok;

   // a select rise while paused abandons the sequence
   assign exec = cs_rise & ~paused;
   assign is_wr = (op_r == `SFPH_OPC_STATUS_WR) && (cnt_r == `SFPH_CNT_STATUS);
   assign is_prog = (op_r == `SFPH_OPC_BYTE_PROG || op_r == `SFPH_OPC_AAI_PROG) && (cnt_r == `SFPH_CNT_PROG);
   assign is_sect = (op_r == `SFPH_OPC_SECT_ERASE) && (cnt_r == `SFPH_CNT_ADDR);
   assign is_chip = (op_r == `SFPH_OPC_CHIP_ERASE) && (cnt_r == `SFPH_CNT_OPC);
   assign wr_ok = wg_s | ~lock_r;

   always_comb begin
      level_nxt = level_r;
      lock_nxt = lock_r;
      req_nxt = 1'b0;
      ref_nxt = 1'b0;
      aop_nxt = aop_r;
      if (exec && is_wr) begin
         if (wr_ok) begin
            level_nxt = {dat_r[`SFPH_SR_LEVEL_HI], dat_r[`SFPH_SR_LEVEL_LO]};
            lock_nxt = dat_r[`SFPH_SR_LOCKDOWN];
         end else begin
            ref_nxt = 1'b1;
         end
      end else if (exec && (is_prog || is_sect)) begin
         aop_nxt = is_prog ? SFPH_ARR_PROG : SFPH_ARR_SECT;
         req_nxt = ~gi.prot;
         ref_nxt = gi.prot;
      end else if (exec && is_chip) begin
         aop_nxt = SFPH_ARR_CHIP;
         req_nxt = (level_r == 2'h0);
         ref_nxt = (level_r != 2'h0);
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         level_r <= `SFPH_LEVEL_RST;
         lock_r <= `SFPH_LOCK_RST;
         req_r <= 1'b0;
         ref_r <= 1'b0;
         aop_r <= SFPH_ARR_NONE;
      end else begin
         level_r <= level_nxt;
         lock_r <= lock_nxt;
         req_r <= req_nxt;
         ref_r <= ref_nxt;
         aop_r <= aop_nxt;
      end
   end

   assign GUARD_LEVEL = level_r;
   assign GUARD_LOCKDOWN = lock_r;
   assign ARRAY_REQ = req_r;
   assign CMD_REFUSED = ref_r;
   assign ARRAY_OP = aop_r;
   assign ARRAY_ADDR = addr_r[18:0];
   assign ARRAY_DATA = dat_r;

   // ==================================================
   // checks
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!ARST_N);

   sample_count_a: assert property (take && cnt_r < `SFPH_CNT_MAX |=> cnt_r == $past(cnt_r) + 6'h01)
      else $error("rising edge not sampled");
   so_on_fall_a: assert property ($changed(so_r) |-> $past(sck_fall))
      else $error("serial output moved off a falling edge");
   deselect_float_a: assert property (cs_s |=> SO_OE_N)
      else $error("output driven while deselected");
   guard_range_a: assert property (exec && (is_prog || is_sect) && gi.prot |=> !ARRAY_REQ && CMD_REFUSED)
      else $error("guarded target not refused");
   guard_all_a: assert property (gi.prot == ((level_r == 2'h3) || (level_r == 2'h2 && gi.addr >= 19'h60000)
      || (level_r == 2'h1 && gi.addr >= 19'h70000)))
      else $error("guard range map wrong");
   chip_erase_a: assert property (exec && is_chip |=> ARRAY_REQ == ($past(level_r) == 2'h0))
      else $error("chip erase guard wrong");
   status_lock_a: assert property (exec && is_wr && !wg_s && lock_r |=> $stable(level_r) && $stable(lock_r))
      else $error("locked status changed");
   status_open_a: assert property (exec && is_wr && wg_s |=> level_r == {$past(dat_r[3]), $past(dat_r[2])})
      else $error("open status write lost");
   pause_enter_a: assert property (!paused && !pn_s && !sck_s && !cs_s |=> paused)
      else $error("pause not entered");
   pause_leave_a: assert property (paused && pn_s && !sck_s |=> !paused)
      else $error("pause not left");
   // a deselect while paused clears the counter, so it is left out here
   pause_float_a: assert property (paused && !cs_s |=> SO_OE_N && $stable(cnt_r))
      else $error("activity while paused");
   pause_drop_a: assert property (paused && cs_rise |=> !ARRAY_REQ && cnt_r == 6'h00)
      else $error("paused sequence not dropped");

endmodule

//--- tb/sfph_host.sv
// host side of the serial link: select, serial clock, data, guard and pause pins
// assumes the bench calls its tasks one at a time from a single process
module sfph_host (
   // timing
   input wire logic sys_clk,
   // pins toward the memory
   output logic sck,
   output logic si,
   output logic cs_n,
   output logic write_guard_n,
   output logic pause_n,
   // pins from the memory
   input wire logic so
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==================================================
   // pin drive, every change lands on a falling system clock edge
   initial begin
      sck = 1'b0;
      si = 1'b0;
      cs_n = 1'b1;
      write_guard_n = 1'b1;
      pause_n = 1'b1;
   end

   task automatic half();
      repeat (4) @(negedge sys_clk); // 100 ns phase of the 200 ns serial clock
   endtask

   task automatic sel(input logic idle);
      sck = idle;
      half();
      cs_n = 1'b0;
      half();
   endtask

   task automatic unsel(input logic idle);
      sck = idle;
      half();
      cs_n = 1'b1;
      si = ~si; // released line must not keep showing the last bit
      half();
   endtask

   task automatic shift(input int n, input logic [47:0] d, output logic [7:0] q);
      q = 8'h00;
      for (int i = n - 1; i >= 0; i--) begin
         sck = 1'b0;
         si = d[i]; // msb first, settled while the clock is low
         half();
         sck = 1'b1;
         q = {q[6:0], so}; // memory moved it on the fall before
         half();
      end
   endtask

   task automatic hold(input logic v);
      sck = 1'b0; // pause only moves while the clock is low
      pause_n = v;
      half();
      half();
   endtask

   task automatic guard(input logic v);
      write_guard_n = v;
      half();
   endtask

   task automatic wiggle();
      repeat (2) begin
         sck = ~sck;
         si = ~si;
         half();
      end
   endtask
endmodule

//--- tb/tb_serial_flash_protect_hold.sv
// self-checking bench of the guard and pause block, host model on the link
// assumes sfph_pkg, sfph_guard_if and the design are compiled before it
module tb_serial_flash_protect_hold;
   timeunit 1ns;
   timeprecision 1ps;
   import sfph_pkg::*;

   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   // pins driven by the host model through its output ports
   wire logic sck, si, cs_n, wg_n, pause_n;
   logic so, so_oe_n, array_req, cmd_refused, lockdown, paused;
   sfph_arr_op_t array_op;
   logic [18:0] array_addr;
   logic [7:0] array_data, q;
   logic [1:0] level;
   int errors = 0;
   int n_tests = 0;
   int n_req = 0;
   int n_ref = 0;

   always #12.5 sys_clk = ~sys_clk;

   sfph_top i_sfph_top (.SYS_CLK(sys_clk), .ARST_N(arst_n), .SCK(sck), .SI(si), .CS_N(cs_n),
      .WRITE_GUARD_N(wg_n), .PAUSE_N(pause_n), .SO(so), .SO_OE_N(so_oe_n), .ARRAY_REQ(array_req),
      .ARRAY_OP(array_op), .ARRAY_ADDR(array_addr), .ARRAY_DATA(array_data),
      .CMD_REFUSED(cmd_refused), .GUARD_LEVEL(level), .GUARD_LOCKDOWN(lockdown), .PAUSED(paused));
   sfph_host i_sfph_host (.sys_clk(sys_clk), .sck(sck), .si(si), .cs_n(cs_n),
      .write_guard_n(wg_n), .pause_n(pause_n), .so(so));

   // ==================================================
   // pulse tallies, so a one-cycle answer is never missed
   always @(posedge sys_clk) begin
      if (array_req === 1'b1) n_req++;
      if (cmd_refused === 1'b1) n_ref++;
   end

   task automatic check(input string name, input logic [18:0] seen, input logic [18:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // one whole command per select, judged by the pulses it leaves behind
   task automatic run(input int n, input logic [47:0] d, input logic idle, input int er, input int ef);
      int r0, f0;
      r0 = n_req;
      f0 = n_ref;
      i_sfph_host.sel(idle);
      i_sfph_host.shift(n, d, q);
      i_sfph_host.unsel(idle);
      repeat (8) @(negedge sys_clk);
      check("accepted", 19'(n_req - r0), 19'(er));
      check("refused", 19'(n_ref - f0), 19'(ef));
   endtask

   // ==================================================
   // scenarios
   task automatic t_reset();
      check("level", 19'(level), 19'h3);
      check("lockdown", 19'(lockdown), 19'h0);
      check("paused", 19'(paused), 19'h0);
      check("oe_n", 19'(so_oe_n), 19'h1);
   endtask

   task automatic t_status();
      run(8, 48'h60, 1'b0, 0, 1);
      run(16, 48'h0180, 1'b0, 0, 0);
      check("level", 19'(level), 19'h0);
      check("lockdown", 19'(lockdown), 19'h1);
      i_sfph_host.guard(1'b0);
      run(16, 48'h010C, 1'b0, 0, 1);
      check("level", 19'(level), 19'h0);
      check("lockdown", 19'(lockdown), 19'h1);
      i_sfph_host.guard(1'b1);
      run(16, 48'h0177, 1'b0, 0, 0);
      check("level", 19'(level), 19'h1);
      check("lockdown", 19'(lockdown), 19'h0);
   endtask

   task automatic t_ranges();
      run(40, 48'h02_07E000_A5, 1'b0, 0, 1);
      run(32, 48'h20_070000, 1'b1, 0, 1);
      run(32, 48'h20_06FFFF, 1'b0, 1, 0);
      check("op", 19'(array_op), 19'(SFPH_ARR_SECT));
      check("addr", array_addr, 19'h6FFFF);
      run(40, 48'hAF_060000_3C, 1'b1, 1, 0);
      check("data", 19'(array_data), 19'h3C);
      run(16, 48'h0108, 1'b0, 0, 0);
      run(32, 48'h20_060000, 1'b0, 0, 1);
      run(32, 48'h20_05FFFF, 1'b0, 1, 0);
      run(8, 48'h60, 1'b1, 0, 1);
   endtask

   task automatic t_read();
      i_sfph_host.sel(1'b1);
      i_sfph_host.shift(8, 48'h05, q);
      i_sfph_host.shift(8, 48'h00, q);
      check("status", 19'(q), 19'h08);
      check("oe_n", 19'(so_oe_n), 19'h0);
      i_sfph_host.unsel(1'b1);
   endtask

   task automatic t_pause();
      int r0;
      run(16, 48'h0100, 1'b0, 0, 0);
      r0 = n_req;
      i_sfph_host.sel(1'b0);
      i_sfph_host.shift(4, 48'h6, q);
      i_sfph_host.hold(1'b0);
      check("paused", 19'(paused), 19'h1);
      check("oe_n", 19'(so_oe_n), 19'h1);
      i_sfph_host.wiggle();
      i_sfph_host.hold(1'b1);
      check("paused", 19'(paused), 19'h0);
      i_sfph_host.shift(4, 48'h0, q);
      i_sfph_host.unsel(1'b0);
      repeat (8) @(negedge sys_clk);
      check("resumed", 19'(n_req - r0), 19'h1);
      check("op", 19'(array_op), 19'(SFPH_ARR_CHIP));
      i_sfph_host.sel(1'b0);
      i_sfph_host.shift(8, 48'h60, q);
      i_sfph_host.hold(1'b0);
      i_sfph_host.unsel(1'b0);
      i_sfph_host.hold(1'b1);
      repeat (8) @(negedge sys_clk);
      check("dropped", 19'(n_req - r0), 19'h1);
      run(8, 48'h60, 1'b0, 1, 0);
   endtask

   // ==================================================
   // main sequence and watchdog
   initial begin
      repeat (20) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_reset();
      t_status();
      t_ranges();
      t_read();
      t_pause();
      close_out();
   end

   initial begin
      repeat (30000) @(posedge sys_clk);
      errors++;
      close_out();
   end
endmodule
